// *** logic/sad_fifo.sv ***
// Sample buffer between converter core and post-processing
`timescale 1ns/10ps
module sad_fifo #(
    parameter int W = 18,
    parameter int D = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    sad_stream_if.snk wr_s,
    sad_stream_if.src rd_s
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);
    localparam logic [PW-1:0] LAST_PTR = PW'(D - 1);

    logic [W-1:0] mem_r [D];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    wire push = wr_s.valid && wr_s.ready;
    wire pop = rd_s.valid && rd_s.ready;

    assign wr_s.ready = cnt_r != FULL_CNT;
    assign rd_s.valid = cnt_r != '0;
    assign rd_s.data = mem_r[rp_r];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wp_r] <= wr_s.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == LAST_PTR) ? '0 : PW'(wp_r + 1'b1);
            end
            if (pop) begin
                rp_r <= (rp_r == LAST_PTR) ? '0 : PW'(rp_r + 1'b1);
            end
            cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
        end
    end
endmodule : sad_fifo

// *** logic/sad_pkg.sv ***
// Constants, register map and state codes of the scan sequencer
package sad_pkg;
    localparam int NCH = 16;
    localparam int RAW_W = 12;
    localparam int RES_W = 16;
    localparam int CH_W = 4;
    localparam int FIFO_W = 2 + CH_W + RAW_W;
    localparam int FIFO_D = 4;

    localparam logic [9:0] OFF_RES_BASE = 10'h000;
    localparam logic [9:0] OFF_CTRL = 10'h100;
    localparam logic [9:0] OFF_CHCFG = 10'h104;
    localparam logic [9:0] OFF_AVGEN = 10'h108;
    localparam logic [9:0] OFF_LIMCFG = 10'h10C;
    localparam logic [9:0] OFF_LIMIT = 10'h110;
    localparam logic [9:0] OFF_SATEN = 10'h114;
    localparam logic [9:0] OFF_EVT = 10'h120;
    localparam logic [9:0] OFF_EVT_MASK = 10'h124;
    localparam logic [9:0] OFF_EVT_MASKED = 10'h128;
    localparam logic [9:0] OFF_SAT = 10'h12C;
    localparam logic [9:0] OFF_SAT_MASK = 10'h130;
    localparam logic [9:0] OFF_SAT_MASKED = 10'h134;
    localparam logic [9:0] OFF_RNG = 10'h138;
    localparam logic [9:0] OFF_RNG_MASK = 10'h13C;
    localparam logic [9:0] OFF_RNG_MASKED = 10'h140;
    localparam logic [9:0] OFF_STATUS = 10'h144;

    localparam int CTRL_START = 0;
    localparam int CTRL_CONT = 1;
    localparam int CTRL_RES = 2;
    localparam int CTRL_SGN_SE = 4;
    localparam int CTRL_SGN_DIFF = 5;
    localparam int CTRL_IL = 6;
    localparam int CTRL_FILT = 7;
    localparam int CTRL_AVG = 8;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_07FE;
    localparam int CHCFG_DIFF = 16;
    localparam int LIM_MODE = 16;

    localparam int EVT_EOS = 0;
    localparam int EVT_OVF = 1;

    localparam int ST_UPD = 31;
    localparam int ST_RNG = 30;
    localparam int ST_SAT = 29;
    localparam int ST_NEW = 27;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] EVT_MASK_RST = 32'h0000_0003;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [2:0] AVG_LOG_MAX = 3'h4;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_SEL = 5'h02,
        S_CONV = 5'h04,
        S_DRAIN = 5'h08,
        S_COPY = 5'h10
    } sad_state_t;
endpackage : sad_pkg

// *** logic/sad_stream_if.sv ***
// Valid/ready stream between the sequencer and its sample buffer
`timescale 1ns/10ps
interface sad_stream_if #(parameter int W = 18) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sad_stream_if

// *** logic/sad_top.sv ***
// Scan sequencer with averaging, result words and event flags
`timescale 1ns/10ps
// Overview of operation
// - Convert each enabled channel in turn, steering selector and core, then average.
// - Core delivers at most 12 bits; narrower resolutions use the low bits.
// - Each channel keeps its own 16-bit result, room for averaged sums.
// - Completed scan sets end-of-scan; it reaches the interrupt only when masked in.
// - All channels interleaved: end-of-scan only after the averaging count of scans.
// - Limit-enabled channels compare against high/low limits and raise a limit event.
// - Saturation-enabled channels raise an event when a raw sample hits a rail code.
// - Overflow and saturation flags are kept and can each feed the interrupt.
// - Result word is 32 bits: 16-bit result plus 4 status bits.
// - Channel X result word sits at base plus X times four, from zero.
// - Bus takes whole words only; an end-of-conversion pulse requests DMA.
// - Filter channel sampling starts only in the filter's first phase.
// - Filter channel: buffered ground on positive input, filter output on negative.
// - Filter channel is formatted with the differential encoding.
// - Lowest input voltage always gives the lowest code.
// - Interrupt is any flag ANDed with its mask; masked values are readable.
// - Writing one to a flag clears it; a same-cycle set still wins.
// - New end-of-scan while the old one is still set raises overflow.
module sad_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [9:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    output logic conv_start,
    output logic [1:0] conv_res,
    output logic conv_diff,
    output logic [3:0] mux_chan,
    output logic mux_pos_agnd,
    output logic mux_neg_filter,
    input wire logic conv_done,
    input wire logic [11:0] conv_data,
    input wire logic filt_phase1,
    output logic irq,
    output logic eoc,
    output logic busy
);
    localparam int N = sad_pkg::NCH;

    sad_pkg::sad_state_t st_r;
    sad_pkg::sad_state_t st_nxt;
    logic [31:0] ctrl_r;
    logic [31:0] chcfg_r;
    logic [15:0] aven_r;
    logic [31:0] limcfg_r;
    logic [31:0] limit_r;
    logic [15:0] saten_r;
    logic [1:0] evt_r;
    logic [1:0] evt_mask_r;
    logic [15:0] sat_r;
    logic [15:0] sat_mask_r;
    logic [15:0] rng_r;
    logic [15:0] rng_mask_r;
    logic [3:0] cur_r;
    logic [4:0] samp_r;
    logic [4:0] scan_r;
    logic [15:0] acc_r [N];
    logic [15:0] work_r [N];
    logic [N-1:0] wk_new_r;
    logic [N-1:0] wk_upd_r;
    logic [N-1:0] wk_sat_r;
    logic [N-1:0] wk_rng_r;
    logic [31:0] res_r [N];

    function automatic logic [4:0] find_en(input logic [15:0] m, input logic [4:0] from);
        logic [4:0] r;
        r = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (m[i] && (5'(i) >= from)) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : find_en

    function automatic logic [11:0] res_mask(input logic [1:0] res);
        return (res == 2'h1) ? 12'h3FF : (res == 2'h2) ? 12'h0FF : 12'hFFF;
    endfunction : res_mask

    function automatic logic [15:0] fmt_raw(input logic [11:0] raw, input logic [1:0] res, input logic sgn);
        logic [11:0] m;
        logic [15:0] v;
        m = raw & res_mask(res);
        v = {4'h0, m};
        // Offset binary to two's complement keeps code order monotonic
        if (sgn) begin
            if (res == 2'h1) begin
                v = {{7{~m[9]}}, m[8:0]};
            end else if (res == 2'h2) begin
                v = {{9{~m[7]}}, m[6:0]};
            end else begin
                v = {{5{~m[11]}}, m[10:0]};
            end
        end
        return v;
    endfunction : fmt_raw

    function automatic logic is_diff(input logic [31:0] cfg, input logic [31:0] ctl, input logic [3:0] ch);
        return cfg[sad_pkg::CHCFG_DIFF + 32'(ch)] || (ctl[sad_pkg::CTRL_FILT] && ch == 4'h0);
    endfunction : is_diff

    // Register bus decode
    wire word_ok = reg_be == 4'hF;
    wire wr_ok = reg_wr && word_ok;
    wire is_res = reg_addr[9:6] == 4'h0;
    wire hit_ctrl = reg_addr == sad_pkg::OFF_CTRL;
    wire hit_chcfg = reg_addr == sad_pkg::OFF_CHCFG;
    wire hit_aven = reg_addr == sad_pkg::OFF_AVGEN;
    wire hit_limcfg = reg_addr == sad_pkg::OFF_LIMCFG;
    wire hit_limit = reg_addr == sad_pkg::OFF_LIMIT;
    wire hit_saten = reg_addr == sad_pkg::OFF_SATEN;
    wire hit_evt = reg_addr == sad_pkg::OFF_EVT;
    wire hit_evtm = reg_addr == sad_pkg::OFF_EVT_MASK;
    wire hit_evtd = reg_addr == sad_pkg::OFF_EVT_MASKED;
    wire hit_sat = reg_addr == sad_pkg::OFF_SAT;
    wire hit_satm = reg_addr == sad_pkg::OFF_SAT_MASK;
    wire hit_satd = reg_addr == sad_pkg::OFF_SAT_MASKED;
    wire hit_rng = reg_addr == sad_pkg::OFF_RNG;
    wire hit_rngm = reg_addr == sad_pkg::OFF_RNG_MASK;
    wire hit_rngd = reg_addr == sad_pkg::OFF_RNG_MASKED;
    wire hit_stat = reg_addr == sad_pkg::OFF_STATUS;
    wire mapped = (is_res && reg_addr[1:0] == 2'h0) || hit_ctrl || hit_chcfg || hit_aven || hit_limcfg
        || hit_limit || hit_saten || hit_evt || hit_evtm || hit_evtd || hit_sat || hit_satm || hit_satd
        || hit_rng || hit_rngm || hit_rngd || hit_stat;

    // Control fields
    wire [1:0] res_sel = ctrl_r[sad_pkg::CTRL_RES +: 2];
    wire interleave = ctrl_r[sad_pkg::CTRL_IL];
    wire filt_en = ctrl_r[sad_pkg::CTRL_FILT];
    wire [2:0] avg_raw = ctrl_r[sad_pkg::CTRL_AVG +: 3];
    wire [2:0] avg_lg = (avg_raw > sad_pkg::AVG_LOG_MAX) ? sad_pkg::AVG_LOG_MAX : avg_raw;
    wire [4:0] avg_m1 = 5'((6'h01 << avg_lg) - 6'h01);
    wire [15:0] chen = chcfg_r[15:0];
    wire start_p = wr_ok && hit_ctrl && reg_wdata[sad_pkg::CTRL_START];

    // Sequencer
    wire [4:0] nx_first = find_en(chen, 5'h00);
    wire [4:0] nx_next = find_en(chen, 5'({1'b0, cur_r} + 5'h01));
    wire seq_avg = aven_r[cur_r] && !interleave;
    wire il_avg = aven_r[cur_r] && interleave;
    wire last_samp = !seq_avg || samp_r == avg_m1;
    wire s_first = seq_avg ? (samp_r == 5'h00) : il_avg ? (scan_r == 5'h00) : 1'b1;
    wire s_commit = seq_avg ? (samp_r == avg_m1) : il_avg ? (scan_r == avg_m1) : 1'b1;
    wire il_all = interleave && ((chen & ~aven_r) == 16'h0000);
    wire eos_due = !il_all || scan_r == avg_m1;
    wire filt_ch = filt_en && cur_r == 4'h0;
    // Filter output is only valid in its first phase
    wire phase_ok = !filt_ch || filt_phase1;

    sad_stream_if #(.W(sad_pkg::FIFO_W)) in_s ();
    sad_stream_if #(.W(sad_pkg::FIFO_W)) out_s ();

    // One conversion in flight, so room at start means room at done
    wire go_conv = st_r == sad_pkg::S_SEL && in_s.ready && phase_ok;
    assign in_s.valid = st_r == sad_pkg::S_CONV && conv_done;
    assign in_s.data = {s_commit, s_first, cur_r, conv_data};

    sad_fifo #(.W(sad_pkg::FIFO_W), .D(sad_pkg::FIFO_D)) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_s(in_s),
        .rd_s(out_s)
    );

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            sad_pkg::S_IDLE: begin
                if (start_p && nx_first[4]) begin
                    st_nxt = sad_pkg::S_SEL;
                end
            end
            sad_pkg::S_SEL: begin
                if (go_conv) begin
                    st_nxt = sad_pkg::S_CONV;
                end
            end
            sad_pkg::S_CONV: begin
                if (conv_done) begin
                    st_nxt = (!last_samp || nx_next[4]) ? sad_pkg::S_SEL : sad_pkg::S_DRAIN;
                end
            end
            sad_pkg::S_DRAIN: begin
                if (!out_s.valid) begin
                    st_nxt = sad_pkg::S_COPY;
                end
            end
            sad_pkg::S_COPY: begin
                st_nxt = (ctrl_r[sad_pkg::CTRL_CONT] && nx_first[4]) ? sad_pkg::S_SEL : sad_pkg::S_IDLE;
            end
            default: st_nxt = sad_pkg::S_IDLE;
        endcase
    end

    wire copy = st_r == sad_pkg::S_COPY;

    // Post-processing, stalled while results are being copied
    assign out_s.ready = !copy;
    wire pop = out_s.valid && out_s.ready;
    wire p_commit = out_s.data[17];
    wire p_first = out_s.data[16];
    wire [3:0] p_ch = out_s.data[15:12];
    wire [11:0] p_raw = out_s.data[11:0];
    wire p_sgn = is_diff(chcfg_r, ctrl_r, p_ch) ? ctrl_r[sad_pkg::CTRL_SGN_DIFF] : ctrl_r[sad_pkg::CTRL_SGN_SE];
    wire [15:0] p_fmt = fmt_raw(p_raw, res_sel, p_sgn);
    wire [15:0] acc_nxt = p_first ? p_fmt : 16'(acc_r[p_ch] + p_fmt);
    wire [11:0] p_m = p_raw & res_mask(res_sel);
    wire p_sat = p_m == 12'h000 || p_m == res_mask(res_sel);
    wire [15:0] lim_lo = limit_r[15:0];
    wire [15:0] lim_hi = limit_r[31:16];
    wire below = p_sgn ? ($signed(acc_nxt) < $signed(lim_lo)) : (acc_nxt < lim_lo);
    wire above = p_sgn ? ($signed(acc_nxt) >= $signed(lim_hi)) : (acc_nxt >= lim_hi);
    wire [1:0] cmp_mode = limcfg_r[sad_pkg::LIM_MODE +: 2];
    wire lim_hit = (cmp_mode == 2'h0) ? below : (cmp_mode == 2'h1) ? (!below && !above)
        : (cmp_mode == 2'h2) ? above : (below || above);
    wire [15:0] ch_oh = 16'h0001 << p_ch;
    wire [15:0] sat_set = (pop && p_sat) ? (ch_oh & saten_r) : 16'h0000;
    wire [15:0] rng_set = (pop && p_commit && lim_hit) ? (ch_oh & limcfg_r[15:0]) : 16'h0000;

    // Event flags; a set in the clearing cycle survives
    wire eos_set = copy && eos_due;
    wire ovf_set = eos_set && evt_r[sad_pkg::EVT_EOS];
    wire [1:0] evt_clr = (wr_ok && hit_evt) ? reg_wdata[1:0] : 2'h0;
    wire [15:0] sat_clr = (wr_ok && hit_sat) ? reg_wdata[15:0] : 16'h0000;
    wire [15:0] rng_clr = (wr_ok && hit_rng) ? reg_wdata[15:0] : 16'h0000;
    wire [1:0] evt_nxt = (evt_r & ~evt_clr) | {ovf_set, eos_set};
    wire [15:0] sat_nxt = (sat_r & ~sat_clr) | sat_set;
    wire [15:0] rng_nxt = (rng_r & ~rng_clr) | rng_set;
    wire [1:0] evt_md = evt_r & evt_mask_r;
    wire [15:0] sat_md = sat_r & sat_mask_r;
    wire [15:0] rng_md = rng_r & rng_mask_r;
    wire irq_nxt = (|evt_md) || (|sat_md) || (|rng_md);

    wire [31:0] stat_word = {18'h0, scan_r, cur_r, st_r};
    wire [31:0] rd_word = is_res ? res_r[reg_addr[5:2]]
        : hit_ctrl ? ctrl_r : hit_chcfg ? chcfg_r : hit_aven ? {16'h0, aven_r}
        : hit_limcfg ? limcfg_r : hit_limit ? limit_r : hit_saten ? {16'h0, saten_r}
        : hit_evt ? {30'h0, evt_r} : hit_evtm ? {30'h0, evt_mask_r} : hit_evtd ? {30'h0, evt_md}
        : hit_sat ? {16'h0, sat_r} : hit_satm ? {16'h0, sat_mask_r} : hit_satd ? {16'h0, sat_md}
        : hit_rng ? {16'h0, rng_r} : hit_rngm ? {16'h0, rng_mask_r} : hit_rngd ? {16'h0, rng_md}
        : hit_stat ? stat_word : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_r <= sad_pkg::CTRL_RST;
            chcfg_r <= sad_pkg::CFG_RST;
            aven_r <= '0;
            limcfg_r <= sad_pkg::CFG_RST;
            limit_r <= sad_pkg::CFG_RST;
            saten_r <= '0;
            evt_mask_r <= sad_pkg::EVT_MASK_RST[1:0];
            sat_mask_r <= '0;
            rng_mask_r <= '0;
        end else if (wr_ok) begin
            if (hit_ctrl) ctrl_r <= reg_wdata & sad_pkg::CTRL_WMASK;
            if (hit_chcfg) chcfg_r <= reg_wdata;
            if (hit_aven) aven_r <= reg_wdata[15:0];
            if (hit_limcfg) limcfg_r <= reg_wdata;
            if (hit_limit) limit_r <= reg_wdata;
            if (hit_saten) saten_r <= reg_wdata[15:0];
            if (hit_evtm) evt_mask_r <= reg_wdata[1:0];
            if (hit_satm) sat_mask_r <= reg_wdata[15:0];
            if (hit_rngm) rng_mask_r <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_rdata <= (reg_rd && word_ok && mapped) ? rd_word : 32'h0000_0000;
            reg_rvalid <= reg_rd;
            reg_err <= (reg_rd || reg_wr) && !(word_ok && mapped);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            evt_r <= '0;
            sat_r <= '0;
            rng_r <= '0;
            irq <= 1'b0;
            eoc <= 1'b0;
        end else begin
            evt_r <= evt_nxt;
            sat_r <= sat_nxt;
            rng_r <= rng_nxt;
            irq <= irq_nxt;
            eoc <= copy;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= sad_pkg::S_IDLE;
            cur_r <= '0;
            samp_r <= '0;
            scan_r <= '0;
            busy <= 1'b0;
        end else begin
            st_r <= st_nxt;
            busy <= st_nxt != sad_pkg::S_IDLE;
            if ((st_r == sad_pkg::S_IDLE && start_p) || copy) begin
                cur_r <= nx_first[3:0];
                samp_r <= '0;
            end else if (st_r == sad_pkg::S_CONV && conv_done) begin
                samp_r <= last_samp ? 5'h00 : 5'(samp_r + 5'h01);
                if (last_samp && nx_next[4]) cur_r <= nx_next[3:0];
            end
            if (st_r == sad_pkg::S_IDLE && start_p) begin
                scan_r <= '0;
            end else if (copy) begin
                scan_r <= (!interleave || scan_r == avg_m1) ? 5'h00 : 5'(scan_r + 5'h01);
            end
        end
    end

    // Converter and selector steering
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            conv_start <= 1'b0;
            conv_res <= '0;
            conv_diff <= 1'b0;
            mux_chan <= '0;
            mux_pos_agnd <= 1'b0;
            mux_neg_filter <= 1'b0;
        end else begin
            conv_start <= go_conv;
            conv_res <= res_sel;
            conv_diff <= is_diff(chcfg_r, ctrl_r, cur_r);
            mux_chan <= cur_r;
            mux_pos_agnd <= filt_ch;
            mux_neg_filter <= filt_ch;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int c = 0; c < N; c++) begin
                acc_r[c] <= '0;
                work_r[c] <= '0;
                res_r[c] <= '0;
            end
            wk_new_r <= '0;
            wk_upd_r <= '0;
            wk_sat_r <= '0;
            wk_rng_r <= '0;
        end else if (copy) begin
            // Results appear only once the whole scan is done
            for (int c = 0; c < N; c++) begin
                res_r[c] <= {wk_upd_r[c], wk_rng_r[c], wk_sat_r[c], 1'b0, wk_new_r[c], 11'h000,
                    wk_upd_r[c] ? work_r[c] : res_r[c][15:0]};
            end
            wk_new_r <= '0;
            wk_upd_r <= '0;
            wk_sat_r <= '0;
            wk_rng_r <= '0;
        end else if (pop) begin
            acc_r[p_ch] <= acc_nxt;
            if (p_commit) work_r[p_ch] <= acc_nxt;
            wk_new_r <= wk_new_r | ch_oh;
            wk_upd_r <= wk_upd_r | (p_commit ? ch_oh : 16'h0000);
            wk_sat_r <= wk_sat_r | (p_sat ? ch_oh : 16'h0000);
            wk_rng_r <= wk_rng_r | rng_set;
        end
    end
endmodule : sad_top

// *** tb/sad_assertions.sv ***
// Port protocol checker for the scan sequencer
`timescale 1ns/10ps
module sad_assertions (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_err,
    input wire logic conv_start,
    input wire logic conv_diff,
    input wire logic [3:0] mux_chan,
    input wire logic mux_pos_agnd,
    input wire logic mux_neg_filter,
    input wire logic conv_done,
    input wire logic filt_phase1,
    input wire logic eoc
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_eoc_pulse; eoc |=> !eoc; endproperty
    a_eoc_pulse: assert property (p_eoc_pulse) else $error("eoc held");
    property p_start_pulse; conv_start |=> !conv_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("conv_start held");
    property p_done_gap; conv_done |=> !conv_start; endproperty
    a_done_gap: assert property (p_done_gap) else $error("start too soon after done");
    property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_stray; !reg_rd |=> !reg_rvalid && reg_rdata == 32'h0; endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray read data");
    property p_word_only; (reg_rd || reg_wr) && reg_be != 4'hF |=> reg_err && reg_rdata == 32'h0; endproperty
    a_word_only: assert property (p_word_only) else $error("partial access taken");
    // Filter channel must sample with inverted routing and diff format
    property p_filt_route; conv_start && mux_pos_agnd |-> mux_neg_filter && conv_diff && mux_chan == 4'h0; endproperty
    a_filt_route: assert property (p_filt_route) else $error("filter routing wrong");
    property p_filt_phase; conv_start && mux_pos_agnd |-> filt_phase1 || $past(filt_phase1); endproperty
    a_filt_phase: assert property (p_filt_phase) else $error("filter sampled off phase");
endmodule : sad_assertions

bind sad_top sad_assertions sad_assertions_inst (.sys_clk(sys_clk), .rst_b(rst_b), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
    .conv_start(conv_start), .conv_diff(conv_diff), .mux_chan(mux_chan), .mux_pos_agnd(mux_pos_agnd),
    .mux_neg_filter(mux_neg_filter), .conv_done(conv_done), .filt_phase1(filt_phase1), .eoc(eoc));

// *** tb/sad_core_model.sv ***
// Behavioural converter core and free-running filter phase
`timescale 1ns/10ps
module sad_core_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic conv_start,
    input wire logic [3:0] mux_chan,
    output logic conv_done = 1'b0,
    output logic [11:0] conv_data = 12'h5A5,
    output logic filt_phase1
);
    logic [2:0] wait_r = 3'h0;
    logic [3:0] ph_r = 4'h0;
    logic [3:0] chan_r = 4'h0;
    // Channel 0 sits on the low rail to provoke saturation
    wire [11:0] code = (chan_r == 4'h0) ? 12'h000 : {chan_r, 8'h10};
    assign filt_phase1 = ph_r[3];
    always @(posedge sys_clk) begin
        ph_r <= ph_r + 4'h1;
        conv_done <= (wait_r == 3'h1);
        // Idle data toggles so a stale sample never looks valid
        conv_data <= (wait_r == 3'h1) ? code : ~conv_data;
        if (!rst_b) begin
            wait_r <= 3'h0;
        end else if (conv_start) begin
            wait_r <= mux_chan[0] ? 3'h1 : 3'h5;
            chan_r <= mux_chan;
        end else if (wait_r != 3'h0) begin
            wait_r <= wait_r - 3'h1;
        end
    end
endmodule : sad_core_model

// *** tb/testbench.sv ***
// Self-checking bench for the scan sequencer
`timescale 1ns/10ps
module testbench;
    typedef struct {logic [9:0] a; logic w; logic [31:0] d; logic [31:0] e;} sad_row_t;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [3:0] reg_be = 4'hF;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, rdq;
    logic reg_rvalid, reg_err, conv_start, conv_diff, mux_pos_agnd, mux_neg_filter, conv_done;
    logic filt_phase1, irq, eoc, busy, errq;
    logic [1:0] conv_res;
    logic [3:0] mux_chan;
    logic [11:0] conv_data;
    int error_cnt = 0;
    int total_checks = 0;
    sad_row_t rows [6] = '{'{sad_pkg::OFF_CTRL, 1'b0, 32'h0, 32'h0}, '{sad_pkg::OFF_EVT, 1'b0, 32'h0, 32'h0},
        '{sad_pkg::OFF_EVT_MASK, 1'b0, 32'h0, 32'h3}, '{sad_pkg::OFF_STATUS, 1'b0, 32'h0, 32'h1},
        '{sad_pkg::OFF_CHCFG, 1'b1, 32'h7, 32'h7}, '{sad_pkg::OFF_SATEN, 1'b1, 32'h1, 32'h1}};
    always #2 sys_clk = ~sys_clk;
    sad_top sad_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_err(reg_err), .conv_start(conv_start), .conv_res(conv_res), .conv_diff(conv_diff),
        .mux_chan(mux_chan), .mux_pos_agnd(mux_pos_agnd), .mux_neg_filter(mux_neg_filter),
        .conv_done(conv_done), .conv_data(conv_data), .filt_phase1(filt_phase1), .irq(irq), .eoc(eoc), .busy(busy));
    sad_core_model sad_core_model_inst (.sys_clk(sys_clk), .rst_b(rst_b), .conv_start(conv_start),
        .mux_chan(mux_chan), .conv_done(conv_done), .conv_data(conv_data), .filt_phase1(filt_phase1));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One access per call; strobes drop at the answering edge
    task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr <= w;
        reg_rd <= !w;
        reg_wdata <= d;
        reg_be <= be;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rdq = reg_rdata;
        errq = reg_err;
    endtask : bus
    task automatic rchk(input string n, input logic [9:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0, 4'hF);
        chk(n, rdq, e);
    endtask : rchk
    task automatic scan(input logic [31:0] ctrl);
        int i;
        bus(sad_pkg::OFF_CTRL, 1'b1, ctrl, 4'hF);
        for (i = 0; i < 800 && eoc !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("eoc", {31'h0, eoc}, 32'h1);
        @(posedge sys_clk);
        #1;
        chk("eoc_pulse", {31'h0, eoc}, 32'h0);
        @(posedge sys_clk);
        #1;
    endtask : scan
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        chk("idle_outs", {29'h0, irq, eoc, busy}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d, 4'hF);
            rchk("row", rows[i].a, rows[i].e);
        end
        scan(32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        rchk("ch0", sad_pkg::OFF_RES_BASE, 32'hA800_0000);
        rchk("ch1", sad_pkg::OFF_RES_BASE + 10'h4, 32'h8800_0110);
        rchk("ch2", sad_pkg::OFF_RES_BASE + 10'h8, 32'h8800_0210);
        rchk("evt_masked", sad_pkg::OFF_EVT_MASKED, 32'h1);
        rchk("sat", sad_pkg::OFF_SAT, 32'h1);
        rchk("sat_masked", sad_pkg::OFF_SAT_MASKED, 32'h0);
        scan(32'h1);
        rchk("ovf", sad_pkg::OFF_EVT, 32'h3);
        bus(sad_pkg::OFF_EVT, 1'b1, 32'h3, 4'hF);
        rchk("evt_clr", sad_pkg::OFF_EVT, 32'h0);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        bus(sad_pkg::OFF_EVT_MASK, 1'b1, 32'h0, 4'hF);
        scan(32'h1);
        chk("irq_off", {31'h0, irq}, 32'h0);
        bus(sad_pkg::OFF_EVT, 1'b1, 32'h3, 4'hF);
        bus(sad_pkg::OFF_EVT_MASK, 1'b1, 32'h3, 4'hF);
        // Filter on channel 0 with signed differential format
        scan(32'hA1);
        rchk("filter", sad_pkg::OFF_RES_BASE, 32'hA800_F800);
        bus(sad_pkg::OFF_AVGEN, 1'b1, 32'h2, 4'hF);
        // Channel 1 limit: at or above 0x100 after averaging
        bus(sad_pkg::OFF_LIMCFG, 1'b1, 32'h0002_0002, 4'hF);
        bus(sad_pkg::OFF_LIMIT, 1'b1, 32'h0100_0000, 4'hF);
        scan(32'h201);
        rchk("avg", sad_pkg::OFF_RES_BASE + 10'h4, 32'hC800_0440);
        rchk("rng", sad_pkg::OFF_RNG, 32'h2);
        bus(sad_pkg::OFF_CTRL, 1'b1, 32'h2, 4'h3);
        chk("err_be", {31'h0, errq}, 32'h1);
        rchk("ctrl_kept", sad_pkg::OFF_CTRL, 32'h200);
        rchk("unmapped", 10'h3FC, 32'h0);
        chk("err_map", {31'h0, errq}, 32'h1);
        bus(sad_pkg::OFF_RES_BASE, 1'b1, 32'h0, 4'hF);
        rchk("res_ro", sad_pkg::OFF_RES_BASE, 32'hA800_0000);
        finish_test();
    end
endmodule : testbench
